//--- common/snp_params.svh
// Constants for the serial nonvolatile memory slave
`ifndef SNP_PARAMS_SVH
`define SNP_PARAMS_SVH

// Command bytes
`define SNP_OP_SET_LATCH   8'h06
`define SNP_OP_CLR_LATCH   8'h04
`define SNP_OP_STATUS_RD   8'h05
`define SNP_OP_STATUS_WR   8'h01
`define SNP_OP_MEM_RD      8'h03
`define SNP_OP_MEM_WR      8'h02

// Array shape and write buffer depth
`define SNP_ADDR_W         15
`define SNP_DATA_W         8
`define SNP_FIFO_DEPTH     8

// Block guard codes
`define SNP_GUARD_NONE     2'h0
`define SNP_GUARD_QUARTER  2'h1
`define SNP_GUARD_HALF     2'h2
`define SNP_GUARD_ALL      2'h3
`define SNP_QUARTER_TOP    2'h3

// Pin sample vector layout and idle levels
`define SNP_PIN_CS         0
`define SNP_PIN_SCK        1
`define SNP_PIN_SI         2
`define SNP_PIN_WP         3
`define SNP_PIN_HOLD       4
`define SNP_PIN_IDLE       5'h19

// Status reset and bit positions
`define SNP_STATUS_RST     8'h00
`define SNP_BIT_PIN_GUARD  7
`define SNP_BIT_GUARD_HI   3
`define SNP_BIT_GUARD_LO   2
`define SNP_BIT_LATCH      1

`endif

//--- common/snp_pkg.sv
// Types for the serial nonvolatile memory slave
`include "snp_params.svh"

package snp_pkg;

   // Command sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_STAT_RD,
      ST_STAT_WR,
      ST_MEM_RD,
      ST_MEM_WR,
      ST_DONE
   } snp_state_t;

   // Status byte layout
   typedef struct packed {
      logic       pin_guard_enable;
      logic [2:0] zero_hi;
      logic       block_guard_hi;
      logic       block_guard_lo;
      logic       write_latch_flag;
      logic       zero_lo;
   } snp_status_t;

   // One buffered array write
   typedef struct packed {
      logic [`SNP_ADDR_W-1:0] addr;
      logic [`SNP_DATA_W-1:0] data;
   } snp_wr_entry_t;

endpackage

//--- rtl/snp_spi_nvram.sv
// Serial slave front end, protection and array of the nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
`include "snp_params.svh"

////////////////////////////////////////////////////////////////////////
// Write buffer, DEPTH must be a power of two
module snp_fifo
#(
   parameter int WIDTH = 23,
   parameter int DEPTH = `SNP_FIFO_DEPTH
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] buf_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Flags and handshakes
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = buf_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers and fill count
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage
   always_ff @(posedge clk_sys)
   begin
      if (push)
         buf_q[wr_ptr_q] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////
// Serial slave with command decode, status and write protection
module snp_spi_nvram
#(
   parameter int ADDR_W = `SNP_ADDR_W
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic power_up_pulse,
   input  wire logic cs_n_pin,
   input  wire logic sck_pin,
   input  wire logic si_pin,
   input  wire logic wp_n_pin,
   input  wire logic hold_n_pin,
   input  wire logic array_stall,
   output logic      so_o,
   output logic      so_oe
);
   snp_pkg::snp_state_t    state_q;
   snp_pkg::snp_status_t   status;
   snp_pkg::snp_wr_entry_t wr_ent_q;
   snp_pkg::snp_wr_entry_t drain_ent;
   logic [4:0]        pin_s1_q;
   logic [4:0]        pin_s2_q;
   logic [4:0]        pin_s3_q;
   logic [4:0]        lvl_q;
   logic [4:0]        lvl_d;
   logic [2:0]        bit_cnt_q;
   logic [6:0]        sh_q;
   logic [7:0]        rx_byte;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        rd_q;
   logic [7:0]        out_byte;
   logic [7:0]        array_q [2**ADDR_W];
   logic              is_wr_q;
   logic              wr_op_q;
   logic              mode3_q;
   logic              seen_rise_q;
   logic              wel_q;
   logic              pin_guard_q;
   logic [1:0]        guard_q;
   logic              wr_pend_q;
   logic              fifo_ready;
   logic              drain_valid;
   logic              cs_fall;
   logic              cs_rise;
   logic              sck_rise;
   logic              sck_fall;
   logic              byte_done;
   logic              status_wr_ok;

   // Block guard decode
   function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [1:0] g);
      case (g)
         `SNP_GUARD_NONE:    guarded = 1'b0;
         `SNP_GUARD_QUARTER: guarded = (a[ADDR_W-1 -: 2] == `SNP_QUARTER_TOP);
         `SNP_GUARD_HALF:    guarded = a[ADDR_W-1];
         default:            guarded = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Three-stage pin synchronisers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= `SNP_PIN_IDLE;
         pin_s2_q <= `SNP_PIN_IDLE;
         pin_s3_q <= `SNP_PIN_IDLE;
         lvl_q    <= `SNP_PIN_IDLE;
      end
      else
      begin
         pin_s1_q <= {hold_n_pin, wp_n_pin, si_pin, sck_pin, cs_n_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         lvl_q    <= lvl_d;
      end
   end

   // Level accepted once stages two and three agree
   assign lvl_d = (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & lvl_q);

   // Edge events, frozen while paused
   assign cs_fall   = lvl_q[`SNP_PIN_CS] & ~lvl_d[`SNP_PIN_CS] & lvl_d[`SNP_PIN_HOLD];
   assign cs_rise   = ~lvl_q[`SNP_PIN_CS] & lvl_d[`SNP_PIN_CS] & lvl_d[`SNP_PIN_HOLD];
   assign sck_rise  = ~lvl_q[`SNP_PIN_SCK] & lvl_d[`SNP_PIN_SCK] & ~lvl_q[`SNP_PIN_CS]
                      & lvl_d[`SNP_PIN_HOLD];
   assign sck_fall  = lvl_q[`SNP_PIN_SCK] & ~lvl_d[`SNP_PIN_SCK] & ~lvl_q[`SNP_PIN_CS]
                      & lvl_d[`SNP_PIN_HOLD];
   assign rx_byte   = {sh_q, lvl_d[`SNP_PIN_SI]};
   assign byte_done = sck_rise & (bit_cnt_q == 3'h7) & (state_q != snp_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////
   // Command sequencer
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= snp_pkg::ST_IDLE;
         bit_cnt_q   <= 3'h0;
         sh_q        <= 7'h00;
         addr_q      <= '0;
         is_wr_q     <= 1'b0;
         wr_op_q     <= 1'b0;
         mode3_q     <= 1'b0;
         seen_rise_q <= 1'b0;
      end
      else if (power_up_pulse)
      begin
         state_q <= snp_pkg::ST_IDLE;
         wr_op_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         state_q     <= snp_pkg::ST_CMD;
         bit_cnt_q   <= 3'h0;
         wr_op_q     <= 1'b0;
         seen_rise_q <= 1'b0;
         mode3_q     <= lvl_d[`SNP_PIN_SCK];
      end
      else if (cs_rise)
         state_q <= snp_pkg::ST_IDLE;
      else if (sck_rise && state_q != snp_pkg::ST_IDLE)
      begin
         sh_q        <= rx_byte[6:0];
         bit_cnt_q   <= bit_cnt_q + 3'h1;
         seen_rise_q <= 1'b1;
         if (byte_done)
         begin
            case (state_q)
               snp_pkg::ST_CMD:
               begin
                  case (rx_byte)
                     `SNP_OP_STATUS_RD: state_q <= snp_pkg::ST_STAT_RD;
                     `SNP_OP_STATUS_WR:
                     begin
                        state_q <= snp_pkg::ST_STAT_WR;
                        wr_op_q <= 1'b1;
                     end
                     `SNP_OP_MEM_RD:
                     begin
                        state_q <= snp_pkg::ST_ADDR_HI;
                        is_wr_q <= 1'b0;
                     end
                     `SNP_OP_MEM_WR:
                     begin
                        state_q <= snp_pkg::ST_ADDR_HI;
                        is_wr_q <= 1'b1;
                        wr_op_q <= 1'b1;
                     end
                     default: state_q <= snp_pkg::ST_DONE;
                  endcase
               end
               snp_pkg::ST_ADDR_HI:
               begin
                  addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
                  state_q            <= snp_pkg::ST_ADDR_LO;
               end
               snp_pkg::ST_ADDR_LO:
               begin
                  addr_q[7:0] <= rx_byte;
                  state_q     <= is_wr_q ? snp_pkg::ST_MEM_WR : snp_pkg::ST_MEM_RD;
               end
               snp_pkg::ST_MEM_RD,
               snp_pkg::ST_MEM_WR:
                  addr_q <= addr_q + 1'b1;
               default: state_q <= snp_pkg::ST_DONE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write latch, volatile
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wel_q <= 1'b0;
      else if (power_up_pulse)
         wel_q <= 1'b0;
      else if (cs_rise && wr_op_q)
         wel_q <= 1'b0;
      else if (byte_done && state_q == snp_pkg::ST_CMD)
      begin
         if (rx_byte == `SNP_OP_SET_LATCH)
            wel_q <= 1'b1;
         else if (rx_byte == `SNP_OP_CLR_LATCH)
            wel_q <= 1'b0;
      end
   end

   // Status write allowed only with latch set and pin guard satisfied
   assign status_wr_ok = wel_q & ~(pin_guard_q & ~lvl_q[`SNP_PIN_WP]);

   // Guard bits, untouched by power_up_pulse
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_guard_q <= 1'(`SNP_STATUS_RST >> `SNP_BIT_PIN_GUARD);
         guard_q     <= 2'h0;
      end
      else if (byte_done && state_q == snp_pkg::ST_STAT_WR && status_wr_ok)
      begin
         pin_guard_q <= rx_byte[`SNP_BIT_PIN_GUARD];
         guard_q     <= {rx_byte[`SNP_BIT_GUARD_HI], rx_byte[`SNP_BIT_GUARD_LO]};
      end
   end

   // Status image with fixed zeros
   always_comb
   begin
      status                  = '0;
      status.pin_guard_enable = pin_guard_q;
      status.block_guard_hi   = guard_q[1];
      status.block_guard_lo   = guard_q[0];
      status.write_latch_flag = wel_q;
   end

   ////////////////////////////////////////////////////////////////////
   // Accepted write byte held until the buffer takes it
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_ent_q  <= '0;
      end
      else if (byte_done && state_q == snp_pkg::ST_MEM_WR && wel_q && !guarded(addr_q, guard_q))
      begin
         wr_pend_q     <= 1'b1;
         wr_ent_q.addr <= addr_q;
         wr_ent_q.data <= rx_byte;
      end
      else if (fifo_ready)
         wr_pend_q <= 1'b0;
   end

   snp_fifo #(
      .WIDTH ($bits(snp_pkg::snp_wr_entry_t)),
      .DEPTH (`SNP_FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_data   (wr_ent_q),
      .in_valid  (wr_pend_q),
      .in_ready  (fifo_ready),
      .out_data  (drain_ent),
      .out_valid (drain_valid),
      .out_ready (~array_stall)
   );

   // Array commit and read port
   always_ff @(posedge clk_sys)
   begin
      if (drain_valid && !array_stall)
         array_q[drain_ent.addr] <= drain_ent.data;
      rd_q <= array_q[addr_q];
   end

   ////////////////////////////////////////////////////////////////////
   // Serial output, bit 7 - bit_cnt of the current byte
   assign out_byte = (state_q == snp_pkg::ST_STAT_RD) ? status : rd_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         so_o  <= 1'b0;
         so_oe <= 1'b0;
      end
      else
      begin
         if (sck_fall && (!mode3_q || seen_rise_q))
            so_o <= out_byte[~bit_cnt_q];
         so_oe <= ~lvl_d[`SNP_PIN_CS] & lvl_d[`SNP_PIN_HOLD]
                  & (state_q == snp_pkg::ST_STAT_RD || state_q == snp_pkg::ST_MEM_RD);
      end
   end
endmodule
`default_nettype wire

//--- bench/snp_spi_nvram_checker.sv
// Port assertions for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module snp_spi_nvram_checker
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic power_up_pulse,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic wp_n_pin,
   input wire logic hold_n_pin,
   input wire logic array_stall,
   input wire logic so_o,
   input wire logic so_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Output released while deselected
   property p_desel;
      cs_n_pin [*8] |-> !so_oe;
   endproperty
   a_desel: assert property (p_desel)
      else $error("so_oe high while deselected");
   // Output released while paused
   property p_hold;
      !hold_n_pin [*8] |-> !so_oe;
   endproperty
   a_hold: assert property (p_hold)
      else $error("so_oe high while paused");
   // Output bits move only in the low clock phase
   property p_chg;
      so_oe && $stable(so_oe) && $changed(so_o) |-> !sck_pin;
   endproperty
   a_chg: assert property (p_chg)
      else $error("so_o changed while sck high");
   // Output held through the high clock phase
   property p_hi;
      (so_oe && sck_pin) [*6] |-> $stable(so_o);
   endproperty
   a_hi: assert property (p_hi)
      else $error("so_o unstable in high phase");
   // Drive starts after the last rise of a command or address byte
   property p_rise_ctx;
      $rose(so_oe) |-> !cs_n_pin && sck_pin;
   endproperty
   a_rise_ctx: assert property (p_rise_ctx)
      else $error("so_oe rose outside a frame");
   // Drive lasts at least half a bit slot
   property p_rise_len;
      $rose(so_oe) |-> so_oe [*8];
   endproperty
   a_rise_len: assert property (p_rise_len)
      else $error("so_oe pulse too short");
   // Drive ends on select rise, pause or byte end
   property p_fell;
      $fell(so_oe) |-> cs_n_pin || !hold_n_pin || sck_pin;
   endproperty
   a_fell: assert property (p_fell)
      else $error("so_oe fell without cause");
   // Outputs quiet right after reset
   property p_reset;
      $rose(rst_n) |-> !so_oe && !so_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs active after reset");
endmodule
bind snp_spi_nvram snp_spi_nvram_checker chk
(
   .clk_sys(clk_sys), .rst_n(rst_n), .power_up_pulse(power_up_pulse), .cs_n_pin(cs_n_pin),
   .sck_pin(sck_pin), .si_pin(si_pin), .wp_n_pin(wp_n_pin), .hold_n_pin(hold_n_pin),
   .array_stall(array_stall), .so_o(so_o), .so_oe(so_oe)
);
`default_nettype wire

//--- bench/snp_host_model.sv
// Host master model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module snp_host_model
(
   input  wire logic clk_sys,
   input  wire logic so_line,
   output logic      cs_n = 1'b1,
   output logic      sck = 1'b0,
   output logic      si = 1'b0,
   output logic      wp_n = 1'b1,
   output logic      hold_n = 1'b1
);
   logic [7:0] rx_byte;
   event       got;
   // Half of the 80 ns link period
   task automatic half();
      repeat (8) @(negedge clk_sys);
   endtask
   // One frame: sent bytes, then read bytes
   task automatic frame(input bit m3, input logic [7:0] tx[$], input int n_rd);
      logic [7:0] b;
      sck = m3;
      half();
      cs_n = 1'b0;
      half();
      for (int k = 0; k < tx.size() + n_rd; k++)
      begin
         b = (k < tx.size()) ? tx[k] : 8'($urandom);
         for (int i = 7; i >= 0; i--)
         begin
            sck = 1'b0;
            si = b[i];
            half();
            sck = 1'b1;
            rx_byte[i] = so_line;
            half();
         end
         if (k >= tx.size())
            -> got;
      end
      sck = m3;
      half();
      cs_n = 1'b1;
      repeat (3) half();
   endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       power_up_pulse = 1'b0;
   logic       array_stall = 1'b0;
   logic       so_last = 1'b0;
   logic [1:0] gd = 2'h0;
   int         error_cnt = 0;
   int         total_checks = 0;
   logic [7:0] exp_q[$];
   logic [7:0] mem[logic [14:0]];
   wire logic  cs_n, sck, si, wp_n, hold_n, so_o, so_oe, so_line;
   // Released line shows the inverse of its last level
   always @(posedge clk_sys)
      if (so_oe)
         so_last <= so_o;
   assign so_line = so_oe ? so_o : ~so_last;
   snp_spi_nvram dut
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .power_up_pulse(power_up_pulse), .cs_n_pin(cs_n),
      .sck_pin(sck), .si_pin(si), .wp_n_pin(wp_n), .hold_n_pin(hold_n), .array_stall(array_stall),
      .so_o(so_o), .so_oe(so_oe)
   );
   snp_host_model host
   (
      .clk_sys(clk_sys), .so_line(so_line), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n)
   );
   ////////////////////////////////////////
   // System clock
   initial
      forever
         #2.5 clk_sys = ~clk_sys;
   // Compare and count
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Block guard decode
   function automatic bit guarded(input logic [14:0] a);
      return gd == 2'h3 || (gd == 2'h2 && a[14]) || (gd == 2'h1 && a[14:13] == 2'h3);
   endfunction
   task automatic rd_stat(input logic [7:0] exp);
      exp_q.push_back(exp);
      host.frame(1'($urandom), '{8'h05}, 1);
   endtask
   task automatic wr_stat(input logic [7:0] v);
      host.frame(1'b0, '{8'h06}, 0);
      host.frame(1'b1, '{8'h01, v}, 0);
   endtask
   // Memory write burst, noting accepted bytes
   task automatic wr_mem(input bit en, input logic [14:0] a, input int n);
      logic [7:0] q[$];
      logic [7:0] d;
      q = '{8'h02, {1'($urandom), a[14:8]}, a[7:0]};
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         q.push_back(d);
         if (en && !guarded(15'(a + i)))
            mem[15'(a + i)] = d;
      end
      if (en)
         host.frame(1'b0, '{8'h06}, 0);
      host.frame(1'b1, q, 0);
   endtask
   task automatic rd_mem(input logic [14:0] a, input int n);
      for (int i = 0; i < n; i++)
         exp_q.push_back(mem[15'(a + i)]);
      host.frame(1'b0, '{8'h03, {1'b1, a[14:8]}, a[7:0]}, n);
   endtask
   // Result watcher
   initial
      forever
      begin
         @(host.got);
         chk("read byte", exp_q.pop_front(), host.rx_byte);
      end
   // Watchdog
   initial
   begin
      #400000;
      error_cnt++;
      finish_test();
   end
   // Main sequence
   initial
   begin
      void'($urandom(70705));
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      rd_stat(8'h00);
      host.frame(1'b0, '{8'h01, 8'h8c}, 0);
      rd_stat(8'h00);
      host.frame(1'b1, '{8'h06, 8'h04}, 0);
      rd_stat(8'h02);
      host.frame(1'b0, '{8'h04}, 0);
      rd_stat(8'h00);
      host.sck = 1'b0;
      repeat (2) host.half();
      host.hold_n = 1'b0;
      repeat (2) host.half();
      host.hold_n = 1'b1;
      array_stall = 1'b1;
      wr_mem(1'b1, 15'h7ffc, 8);
      array_stall = 1'b0;
      wr_mem(1'b0, 15'h7ffe, 1);
      rd_mem(15'h7ffc, 8);
      for (int g = 0; g < 4; g++)
      begin
         gd = 2'(g);
         wr_stat({4'h0, gd, 2'h0});
         wr_mem(1'b1, 15'h3fff, 2);
         wr_mem(1'b1, 15'h5fff, 2);
         rd_stat({4'h0, gd, 2'h0});
         rd_mem(15'h3fff, 2);
         rd_mem(15'h5fff, 2);
      end
      wr_stat(8'hff);
      rd_stat(8'h8c);
      host.wp_n = 1'b0;
      wr_stat(8'h00);
      rd_stat(8'h8c);
      host.frame(1'b0, '{8'h06}, 0);
      power_up_pulse = 1'b1;
      @(negedge clk_sys);
      power_up_pulse = 1'b0;
      rd_stat(8'h8c);
      host.wp_n = 1'b1;
      wr_stat(8'h00);
      rd_stat(8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
